// ### core/t1_sf_pkg.sv
// constants and carrier types for the twelve-frame multiframe formatter
package t1_sf_pkg;
  localparam int          FIFO_DEPTH  = 4;
  localparam int          SLOT_BITS   = 8;
  // frame, slot and bit counters count from zero
  localparam logic [3:0]  LAST_FRAME  = 4'hb;
  localparam logic [4:0]  LAST_SLOT   = 5'h17;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [3:0]  SIG_A_FRAME = 4'h5;
  localparam logic [3:0]  SIG_B_FRAME = 4'hb;
  // framing bits of frames 1..12, frame 1 in the msb
  localparam logic [11:0] FBIT_PAT    = 12'h8dc;
  // data-multiplex sync byte 1 0 1 1 1 Y R 0, msb sent first
  localparam logic [7:0]  SYNC_BASE   = 8'hb8;
  localparam int          Y_POS       = 2;
  localparam int          R_POS       = 1;
  localparam logic [7:0]  IDLE_BYTE   = 8'hff;
  // values after reset
  localparam logic [3:0]  FRAME_RST   = 4'h0;
  localparam logic [4:0]  SLOT_RST    = 5'h00;
  localparam logic [2:0]  BIT_RST     = 3'h0;
  localparam logic [7:0]  SHIFT_RST   = 8'h00;

  typedef struct packed {
    logic [7:0] data;
    logic       sig_a;
    logic       sig_b;
  } slot_word_t;

  typedef struct packed {
    logic bit_val;
    logic strobe;
    logic frame_start;
    logic mf_start;
  } line_out_t;

  typedef enum logic {ST_FBIT = 1'b0, ST_SLOT = 1'b1} fmt_state_t;

  localparam slot_word_t IDLE_WORD = '{data: IDLE_BYTE, sig_a: 1'b1, sig_b: 1'b1};
  localparam line_out_t  LINE_RST  = '{bit_val: 1'b0, strobe: 1'b0, frame_start: 1'b0,
                                       mf_start: 1'b0};
endpackage

// ### core/t1_superframe_formatter.sv
// twelve-frame multiframe transmit formatter with its slot fifo
`timescale 1ns/1ps
`default_nettype none

module slot_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // draining side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    wp_nxt;
  logic [AW-1:0]    rp_r;
  logic [AW-1:0]    rp_nxt;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             rdy_r;
  logic             rdy_nxt;
  logic             push;
  logic             pop;

  // pointer and fill arithmetic; depth is a power of two so pointers wrap freely
  always_comb begin
    push    = in_valid && rdy_r;
    pop     = out_valid && out_ready;
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
    rdy_nxt = (cnt_nxt != CW'(DEPTH));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // storage has no reset; out_data always shows the slot at the read pointer, valid only while out_valid is high
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // ready is registered so the filling side never sees a combinational path
  assign in_ready  = rdy_r;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];

  // a full fifo must leave its write pointer alone, or a stored word is lost
  fifo_full_a: assert property (@(posedge clk) disable iff (rst)
    (cnt_r == CW'(DEPTH)) |=> $stable(wp_r))
    else $error("fifo accepts while full");
endmodule

module t1_superframe_formatter (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // channelised slot words from the system side
  input  wire t1_sf_pkg::slot_word_t slot_in,
  input  wire logic                  slot_valid,
  output logic                       slot_ready,
  // format controls, same clock domain
  input  wire logic                  dm_mode,
  input  wire logic                  yellow_alarm,
  input  wire logic                  r_bit,
  // serial line side
  input  wire logic                  line_tick_pin,
  output t1_sf_pkg::line_out_t       line_r,
  output logic                       underrun_r,
  output logic [3:0]                 frame_r
);
  import t1_sf_pkg::*;

  logic       tk_s1_r;
  logic       tk_s2_r;
  logic       tk_s3_r;
  logic       tick;
  slot_word_t fifo_word;
  logic       fifo_valid;
  logic       fifo_pop;
  logic       ready_i;
  fmt_state_t st_r;
  fmt_state_t st_nxt;
  logic [3:0] frm_nxt;
  logic [4:0] slot_r;
  logic [4:0] slot_nxt;
  logic [2:0] bit_r;
  logic [2:0] bit_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  line_out_t  line_nxt;
  logic       under_nxt;
  logic       sync_slot;
  logic [7:0] sync_byte;
  logic [7:0] load_byte;
  slot_word_t cur_word;
  logic [3:0] fidx;

  // the line bit clock pin passes three flops; only the second is edge-detected
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tk_s1_r <= 1'b0;
      tk_s2_r <= 1'b0;
      tk_s3_r <= 1'b0;
    end else begin
      tk_s1_r <= line_tick_pin;
      tk_s2_r <= tk_s1_r;
      tk_s3_r <= tk_s2_r;
    end
  end

  assign tick = tk_s2_r && !tk_s3_r;

  // four-word buffer between system side and serialiser absorbs frame-bit gaps
  slot_fifo #(
    .WIDTH ($bits(slot_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) slot_fifo_i (
    .clk       (clk),
    .rst       (rst),
    .in_data   (slot_in),
    .in_valid  (slot_valid),
    .in_ready  (ready_i),
    .out_data  (fifo_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // byte chosen at the first bit of each slot
  always_comb begin
    fidx      = 4'(LAST_FRAME - frame_r);
    // sync byte in last slot of frames 1-11
    sync_slot = dm_mode && (slot_r == LAST_SLOT) && (frame_r != LAST_FRAME);
    sync_byte = SYNC_BASE;
    sync_byte[Y_POS] = !yellow_alarm;
    sync_byte[R_POS] = r_bit;
    cur_word  = fifo_valid ? fifo_word : IDLE_WORD;
    load_byte = sync_slot ? sync_byte : cur_word.data;
    // robbed signalling bit in frames 6 and 12
    if (!sync_slot && (frame_r == SIG_A_FRAME)) begin
      load_byte[0] = cur_word.sig_a;
    end else if (!sync_slot && (frame_r == SIG_B_FRAME)) begin
      load_byte[0] = cur_word.sig_b;
    end
    // sync slots consume no system word, so the fifo holds its data
    fifo_pop  = tick && (st_r == ST_SLOT) && (bit_r == BIT_RST) && !sync_slot;
  end

  // next-state for the frame, slot and bit counters and the line bit
  always_comb begin
    st_nxt   = st_r;
    frm_nxt  = frame_r;
    slot_nxt = slot_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    line_nxt = line_r;
    line_nxt.strobe      = 1'b0;
    line_nxt.frame_start = 1'b0;
    line_nxt.mf_start    = 1'b0;
    under_nxt = 1'b0;
    if (tick) begin
      line_nxt.strobe = 1'b1;
      unique case (st_r)
        ST_FBIT: begin
          // terminal bit in odd frames from the pattern
          // signalling bit in even frames from the pattern
          line_nxt.bit_val     = FBIT_PAT[fidx];
          line_nxt.frame_start = 1'b1;
          line_nxt.mf_start    = (frame_r == FRAME_RST);
          // twenty-four slots follow the framing bit
          st_nxt   = ST_SLOT;
          slot_nxt = SLOT_RST;
          bit_nxt  = BIT_RST;
        end
        ST_SLOT: begin
          // msb of each slot goes out first
          if (bit_r == BIT_RST) begin
            line_nxt.bit_val = load_byte[7];
            sh_nxt    = {load_byte[6:0], 1'b0};
            under_nxt = !sync_slot && !fifo_valid;
          end else begin
            line_nxt.bit_val = sh_r[7];
            sh_nxt = {sh_r[6:0], 1'b0};
          end
          bit_nxt = 3'(bit_r + 1'b1);
          if (bit_r == LAST_BIT) begin
            if (slot_r == LAST_SLOT) begin
              st_nxt  = ST_FBIT;
              frm_nxt = (frame_r == LAST_FRAME) ? FRAME_RST : 4'(frame_r + 1'b1);
            end else begin
              slot_nxt = 5'(slot_r + 1'b1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r       <= ST_FBIT;
      frame_r    <= FRAME_RST;
      slot_r     <= SLOT_RST;
      bit_r      <= BIT_RST;
      sh_r       <= SHIFT_RST;
      line_r     <= LINE_RST;
      underrun_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      frame_r    <= frm_nxt;
      slot_r     <= slot_nxt;
      bit_r      <= bit_nxt;
      sh_r       <= sh_nxt;
      line_r     <= line_nxt;
      underrun_r <= under_nxt;
    end
  end

  // ready is the fifo's own registered flag; the fifo itself gates the push
  assign slot_ready = ready_i;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  fbit_pattern_a: assert property (
    tick && (st_r == ST_FBIT) |=> line_r.strobe && line_r.frame_start
      && (line_r.bit_val == FBIT_PAT[$past(fidx)]))
    else $error("framing bit does not follow pattern");

  frame_wrap_a: assert property (
    tick && (st_r == ST_SLOT) && (bit_r == LAST_BIT) && (slot_r == LAST_SLOT)
      && (frame_r == LAST_FRAME) |=> (frame_r == FRAME_RST) && (st_r == ST_FBIT))
    else $error("frame counter did not wrap after twelfth frame");

  frame_range_a: assert property (
    frame_r <= LAST_FRAME)
    else $error("frame counter out of range");

  slot_start_a: assert property (
    tick && (st_r == ST_FBIT) |=> (st_r == ST_SLOT) && (slot_r == SLOT_RST)
      && (bit_r == BIT_RST))
    else $error("slot sequence not restarted after framing bit");

  robbed_a_a: assert property (
    fifo_pop && fifo_valid && (frame_r == SIG_A_FRAME)
      |=> sh_r[1] == $past(fifo_word.sig_a))
    else $error("A signalling bit not placed in bit 8");

  robbed_b_a: assert property (
    fifo_pop && fifo_valid && (frame_r == SIG_B_FRAME)
      |=> sh_r[1] == $past(fifo_word.sig_b))
    else $error("B signalling bit not placed in bit 8");

  sync_alarm_a: assert property (
    tick && (st_r == ST_SLOT) && (bit_r == BIT_RST) && sync_slot
      |=> line_r.bit_val && (sh_r[Y_POS + 1] == !$past(yellow_alarm)) && !sh_r[1])
    else $error("sync byte or alarm bit wrong");

  sync_rbit_a: assert property (
    tick && (st_r == ST_SLOT) && (bit_r == BIT_RST) && sync_slot
      |=> sh_r[R_POS + 1] == $past(r_bit))
    else $error("channel bit not passed through");

  msb_first_a: assert property (
    fifo_pop && fifo_valid && (frame_r != SIG_A_FRAME) |=> line_r.strobe
      && (line_r.bit_val == $past(fifo_word.data[7])))
    else $error("slot msb not sent first");

  strobe_pulse_a: assert property (
    line_r.strobe |=> !line_r.strobe)
    else $error("line strobe longer than one cycle");
endmodule

`default_nettype wire

// ### bench/line_partner.sv
// line-side model: makes bit ticks and collects the formatted bitstream
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // tick budget and line
  input  wire logic [15:0]          limit,
  output logic                      tick,
  input  wire t1_sf_pkg::line_out_t line_r
);
  import t1_sf_pkg::*;
  int   issued = 0;
  int   ph = 0;
  logic bits[$];
  logic fs_q[$];
  logic ms_q[$];
  // tick high 3 clk and low 3 clk, well clear of the merge limit; reset parks it low
  always @(negedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else if (ph == 0 && issued < int'(limit)) begin
      tick <= 1'b1;
      issued <= issued + 1;
      ph <= 1;
    end else if (ph != 0) begin
      tick <= (ph < 3);
      ph <= (ph == 5) ? 0 : ph + 1;
    end
  end
  always @(posedge clk) begin
    if (!rst && line_r.strobe === 1'b1) begin
      bits.push_back(line_r.bit_val);
      fs_q.push_back(line_r.frame_start);
      ms_q.push_back(line_r.mf_start);
    end
  end
endmodule
`default_nettype wire

// ### bench/t1_superframe_formatter_tb.sv
// self-checking bench for the twelve-frame multiframe formatter
`timescale 1ns/1ps
`default_nettype none
module t1_superframe_formatter_tb;
  import t1_sf_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  slot_word_t  slot_in = IDLE_WORD;
  logic        slot_valid = 1'b0;
  logic        dm_mode = 1'b0;
  logic        yellow_alarm = 1'b0;
  logic        r_bit = 1'b0;
  logic        slot_ready;
  line_out_t   line_r;
  logic        underrun_r;
  logic [3:0]  frame_r;
  logic        tick;
  logic [15:0] limit = 16'h0000;
  int          wn = 0;
  int          pos = 0;
  int          wx = 0;
  int          un_cnt = 0;
  int          mismatches = 0;
  int          check_count = 0;

  always #2 clk = ~clk;

  function automatic slot_word_t mk(input int n);
    mk = '{data: n[7:0] ^ 8'h5a, sig_a: n[0], sig_b: ~n[0]};
  endfunction

  // word source: next word offered once the last one was taken
  always @(posedge clk) if (slot_valid && slot_ready === 1'b1) wn <= wn + 1;
  always @(negedge clk) slot_in <= mk(wn);
  always @(posedge clk) if (underrun_r === 1'b1) un_cnt <= un_cnt + 1;

  t1_superframe_formatter t1_superframe_formatter_i (
    .clk(clk), .rst(rst), .slot_in(slot_in), .slot_valid(slot_valid),
    .slot_ready(slot_ready), .dm_mode(dm_mode), .yellow_alarm(yellow_alarm),
    .r_bit(r_bit), .line_tick_pin(tick), .line_r(line_r),
    .underrun_r(underrun_r), .frame_r(frame_r));
  line_partner line_partner_i (
    .clk(clk), .rst(rst), .limit(limit), .tick(tick), .line_r(line_r));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_bits(input int n);
    for (int i = 0; i < 40000 && line_partner_i.bits.size() < n; i++) @(posedge clk);
    repeat (8) @(negedge clk);
  endtask

  // decode one whole multiframe from the captured line bits
  task automatic chk_mf(input logic dm);
    slot_word_t cw;
    logic       sy;
    logic       e;
    for (int f = 0; f < 12; f++) begin
      for (int k = 0; k < 193; k++) begin
        if (k == 0) begin
          chk(line_partner_i.bits[pos], FBIT_PAT[11-f]);
          chk(line_partner_i.ms_q[pos], f == 0);
        end else begin
          if ((k - 1) % 8 == 0) begin
            sy = dm && k == 185 && f < 11;
            cw = mk(wx);
            if (sy) begin
              cw.data = SYNC_BASE;
              cw.data[Y_POS] = !yellow_alarm;
              cw.data[R_POS] = r_bit;
            end else begin
              wx++;
            end
          end
          e = cw.data[7 - (k - 1) % 8];
          if (k % 8 == 0 && !sy && f == 5) e = cw.sig_a;
          if (k % 8 == 0 && !sy && f == 11) e = cw.sig_b;
          chk(line_partner_i.bits[pos], e);
        end
        chk(line_partner_i.fs_q[pos], k == 0);
        pos++;
      end
    end
    chk(frame_r, 4'h0);
  endtask

  task automatic t_fifo_full();
    slot_valid = 1'b1;
    repeat (10) @(negedge clk);
    chk(slot_ready, 1'b0);
    chk(wn[7:0], 8'(FIFO_DEPTH));
  endtask

  task automatic t_frames(input logic dm, input logic ya, input logic rb);
    dm_mode = dm;
    yellow_alarm = ya;
    r_bit = rb;
    limit = limit + 16'd2316;
    wait_bits(pos + 2316);
    chk_mf(dm);
  endtask

  // starved fifo: four queued words, then idle bytes with a pulse each
  task automatic t_underrun();
    int         u0;
    slot_word_t w;
    slot_valid = 1'b0;
    u0 = un_cnt;
    limit = limit + 16'd65;
    wait_bits(pos + 65);
    chk(line_partner_i.bits[pos], FBIT_PAT[11]);
    for (int i = 1; i < 33; i++) begin
      w = mk(wx + (i - 1) / 8);
      chk(line_partner_i.bits[pos + i], w.data[7 - (i - 1) % 8]);
    end
    for (int i = 33; i < 65; i++) chk(line_partner_i.bits[pos + i], 1'b1);
    chk(8'(un_cnt - u0), 8'h04);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_fifo_full();
    t_frames(1'b0, 1'b0, 1'b0);
    t_frames(1'b1, 1'b1, 1'b1);
    t_frames(1'b1, 1'b0, 1'b0);
    t_underrun();
    tally_and_finish();
  end

  // watchdog well beyond four multiframes of ticks
  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
